// ===== uflt_top.sv
// Undercurrent fault response controller with its configuration words.
// Functional notes
// R1 - Keep 8-bit undercurrent action byte at command code 0x4C.
// R2 - Any undercurrent fault drives alert low and sets fault flag.
// R3 - Fault sets only the undercurrent status bit.
// R4 - Response 00 keeps output running despite the fault.
// R5 - Response 01 runs for delay, then retries if fault remains; the code follows the retry field, latching off for retry 000.
// R6 - Response 10 disables output at once, then follows retry field.
// R7 - Response 11 holds output off until fault disappears.
// R8 - Retry 000 never restarts; output off until fault cleared.
// R9 - Retry 001..110 allow 1..6 restarts, then latch off.
// R10 - Retry 111 retries forever until off, bias lost, other fault; the code has no bias-lost input, so only off or other fault ends it.
// R11 - Restart attempts start spaced by delay field times retry unit.
// R12 - Delay field 0..7 counts zero to seven units directly.
// R13 - Keep-operating delay uses 10 ms per unit.
// R14 - Retry spacing uses 8.2 ms per unit.
// R15 - Keep 16-bit over-temperature threshold at command code 0x4F.
// R16 - Keep 16-bit undercurrent threshold at command code 0x4B.
// R17 - Fault declared when measured current is below threshold.
`timescale 1ns/1ps
`default_nettype none
module uflt_top
#(
   parameter int P_OPER_UNIT_CYC  = uflt_pkg::OPER_UNIT_CYC,
   parameter int P_RETRY_UNIT_CYC = uflt_pkg::RETRY_UNIT_CYC
)
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   input  wire logic [7:0]  i_cmd_code,
   input  wire logic [15:0] i_wr_data,
   input  wire logic [15:0] i_iout_meas,
   input  wire logic        i_output_on,
   input  wire logic        i_other_shutdown,
   input  wire logic        i_clear_fault,
   output logic [15:0]      o_rd_data,
   output logic             o_rd_valid,
   output logic             o_output_en,
   output logic             o_alert_line_n,
   output logic             o_status_uc,
   output logic [15:0]      o_overtemp_trip_threshold
);
   typedef enum logic [2:0] {
      ST_RUN,
      ST_OPER_DELAY,
      ST_OFF_WAIT,
      ST_RESTART,
      ST_LATCHED,
      ST_HOLD_OFF
   } uflt_state_e;

   localparam logic [uflt_pkg::UNIT_CNT_W-1:0] OPER_CYC =
      uflt_pkg::UNIT_CNT_W'(P_OPER_UNIT_CYC);
   localparam logic [uflt_pkg::UNIT_CNT_W-1:0] RETRY_CYC =
      uflt_pkg::UNIT_CNT_W'(P_RETRY_UNIT_CYC);

   // Picks the state that a fault which turns the output off leads to.
   function automatic uflt_state_e off_target(input logic [2:0] retries);
      return (retries == uflt_pkg::RETRY_NONE) ? ST_LATCHED : ST_OFF_WAIT;
   endfunction

   uflt_state_e  state_r;
   uflt_state_e  state_nxt;
   logic [7:0]   uc_action_r;
   logic [15:0]  uc_thresh_r;
   logic [2:0]   attempts_r;
   logic [2:0]   attempts_nxt;
   logic         status_nxt;
   logic         en_nxt;
   logic         tmr_load;
   logic         tmr_oper;
   logic         tmr_done;
   logic [uflt_pkg::UNIT_CNT_W-1:0] tmr_cycles;

   wire          wr_uc_thresh = i_wr_en &&
                                (i_cmd_code == uflt_pkg::CMD_UC_THRESH);
   wire          wr_uc_action = i_wr_en &&
                                (i_cmd_code == uflt_pkg::CMD_UC_ACTION);
   wire          wr_ot_thresh = i_wr_en &&
                                (i_cmd_code == uflt_pkg::CMD_OT_THRESH);
   wire [1:0]    resp_mode    =
      uc_action_r[uflt_pkg::RESP_MSB:uflt_pkg::RESP_LSB];
   wire [2:0]    retry_set    =
      uc_action_r[uflt_pkg::RETRY_MSB:uflt_pkg::RETRY_LSB];
   wire [2:0]    delay_units  =
      uc_action_r[uflt_pkg::DELAY_MSB:uflt_pkg::DELAY_LSB];
   wire          fault_raw    = (i_iout_meas < uc_thresh_r); // R17
   wire          uc_fault     = fault_raw && o_output_en;
   wire          run_ok       = i_output_on && !i_other_shutdown;
   wire          more_retries = (retry_set == uflt_pkg::RETRY_FOREVER) ||
                                (attempts_r < retry_set);
   wire [15:0]   rd_mux       =
      (i_cmd_code == uflt_pkg::CMD_UC_THRESH) ? uc_thresh_r :
      (i_cmd_code == uflt_pkg::CMD_UC_ACTION) ? {8'h00, uc_action_r} :
      (i_cmd_code == uflt_pkg::CMD_OT_THRESH) ? o_overtemp_trip_threshold :
      16'h0000;

   // Configuration words and read port.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         uc_thresh_r               <= uflt_pkg::UC_THRESH_RST;
         uc_action_r               <= uflt_pkg::UC_ACTION_RST;
         o_overtemp_trip_threshold <= uflt_pkg::OT_THRESH_RST;
         o_rd_data                 <= 16'h0000;
         o_rd_valid                <= 1'b0;
      end
      else
      begin
         if (wr_uc_thresh)
            uc_thresh_r <= i_wr_data; // R16
         if (wr_uc_action)
            uc_action_r <= i_wr_data[7:0]; // R1
         if (wr_ot_thresh)
            o_overtemp_trip_threshold <= i_wr_data; // R15
         o_rd_valid <= i_rd_en;
         o_rd_data  <= i_rd_en ? rd_mux : 16'h0000;
      end
   end

   // The delay field is used directly as a unit count.
   uflt_timer u_timer
   (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (i_rst_n),
      .i_load        (tmr_load),
      .i_units       (delay_units), // R12
      .i_unit_cycles (tmr_cycles),
      .i_abort       (!run_ok),
      .o_done        (tmr_done)
   );
   assign tmr_cycles = tmr_oper ? OPER_CYC : RETRY_CYC; // R13 R14

   // Response sequencing.
   always_comb
   begin
      state_nxt    = state_r;
      attempts_nxt = attempts_r;
      tmr_load     = 1'b0;
      tmr_oper     = 1'b0;
      case (state_r)
         ST_RUN:
         begin
            attempts_nxt = 3'h0;
            if (uc_fault)
            begin
               case (resp_mode)
                  uflt_pkg::RESP_IGNORE:
                     state_nxt = ST_RUN; // R4
                  uflt_pkg::RESP_DELAY_RETRY:
                  begin
                     state_nxt = ST_OPER_DELAY; // R5
                     tmr_load  = 1'b1;
                     tmr_oper  = 1'b1;
                  end
                  uflt_pkg::RESP_DISABLE:
                  begin
                     // R6 R8
                     state_nxt = off_target(retry_set);
                     tmr_load  = 1'b1;
                  end
                  default:
                     state_nxt = ST_HOLD_OFF; // R7
               endcase
            end
         end
         ST_OPER_DELAY:
         begin
            if (tmr_done && fault_raw)
            begin
               // R5 R8
               state_nxt = off_target(retry_set);
               tmr_load  = 1'b1;
            end
            else if (tmr_done)
               state_nxt = ST_RUN;
         end
         ST_OFF_WAIT:
         begin
            if (tmr_done)
            begin
               state_nxt    = ST_RESTART; // R11
               tmr_load     = 1'b1;
               attempts_nxt = attempts_r + 3'h1;
            end
         end
         ST_RESTART:
         begin
            if (tmr_done && !fault_raw)
               state_nxt = ST_RUN;
            else if (tmr_done && more_retries)
            begin
               // R9 R10 R11
               tmr_load = 1'b1;
               if (retry_set != uflt_pkg::RETRY_FOREVER)
                  attempts_nxt = attempts_r + 3'h1;
            end
            else if (tmr_done)
               state_nxt = ST_LATCHED; // R9
         end
         ST_LATCHED:
         begin
            if (i_clear_fault)
               state_nxt = ST_RUN; // R8
         end
         ST_HOLD_OFF:
         begin
            if (!fault_raw)
               state_nxt = ST_RUN; // R7
         end
         default:
            state_nxt = ST_RUN;
      endcase
      // Being commanded off or shut down by another fault ends retrying.
      if (!run_ok)
      begin
         state_nxt    = ST_RUN; // R10
         attempts_nxt = 3'h0;
         tmr_load     = 1'b0;
      end
   end

   assign en_nxt = run_ok &&
                   ((state_nxt == ST_RUN) || (state_nxt == ST_OPER_DELAY) ||
                    (state_nxt == ST_RESTART));
   // Set wins over a simultaneous clear.
   assign status_nxt = (o_status_uc && !i_clear_fault) || uc_fault; // R2 R3

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         state_r        <= ST_RUN;
         attempts_r     <= 3'h0;
         o_output_en    <= 1'b0;
         o_status_uc    <= 1'b0;
         o_alert_line_n <= 1'b1;
      end
      else
      begin
         state_r        <= state_nxt;
         attempts_r     <= attempts_nxt;
         o_output_en    <= en_nxt;
         o_status_uc    <= status_nxt; // R3
         o_alert_line_n <= !status_nxt; // R2
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   a_action_write: assert property // R1
      (wr_uc_action |=> uc_action_r == $past(i_wr_data[7:0]))
      else $error("Action byte write not stored.");
   a_alert_status: assert property // R2
      (o_status_uc |-> !o_alert_line_n)
      else $error("Alert not low while fault flag set.");
   a_fault_sets_flag: assert property // R3
      (uc_fault |=> o_status_uc && !o_alert_line_n)
      else $error("Fault did not set flag and alert.");
   a_ignore_keeps_on: assert property // R4
      (state_r == ST_RUN && uc_fault && resp_mode == uflt_pkg::RESP_IGNORE
       && run_ok |=> o_output_en)
      else $error("Ignore mode dropped the output.");
   a_delay_keeps_on: assert property // R5
      (state_r == ST_RUN && uc_fault &&
       resp_mode == uflt_pkg::RESP_DELAY_RETRY && run_ok
       |=> state_r == ST_OPER_DELAY && o_output_en)
      else $error("Delay mode did not keep running.");
   a_disable_now: assert property // R6
      (state_r == ST_RUN && uc_fault && resp_mode == uflt_pkg::RESP_DISABLE
       |=> !o_output_en)
      else $error("Disable mode left output on.");
   a_hold_release: assert property // R7
      (state_r == ST_HOLD_OFF && !fault_raw && run_ok
       |=> state_r == ST_RUN && o_output_en)
      else $error("Hold mode did not release.");
   a_no_retry_latch: assert property // R8
      (state_r == ST_RUN && uc_fault && resp_mode == uflt_pkg::RESP_DISABLE
       && retry_set == uflt_pkg::RETRY_NONE && run_ok
       |=> state_r == ST_LATCHED)
      else $error("Zero retry did not latch off.");
   a_attempt_limit: assert property // R9
      (state_r == ST_RESTART && retry_set != uflt_pkg::RETRY_FOREVER
       && $stable(retry_set) |-> attempts_r <= retry_set)
      else $error("More restarts than allowed.");
   a_off_stops_retry: assert property // R10
      (!run_ok |=> state_r == ST_RUN && !o_output_en)
      else $error("Retrying continued while off.");

   c_delay_retry: cover property
      (state_r == ST_OPER_DELAY ##[1:300] state_r == ST_RESTART);
   c_latch_after_retries: cover property
      (state_r == ST_RESTART ##1 state_r == ST_LATCHED);
   c_hold_release: cover property
      (state_r == ST_HOLD_OFF ##1 state_r == ST_RUN);
   c_endless_retry: cover property
      (state_r == ST_RESTART && retry_set == uflt_pkg::RETRY_FOREVER
       && tmr_done);
endmodule
`default_nettype wire

// ===== uflt_pkg.sv
// Constants shared by the undercurrent fault response block.
package uflt_pkg;
   // Command codes of the configuration words.
   localparam logic [7:0]  CMD_UC_THRESH     = 8'h4B;
   localparam logic [7:0]  CMD_UC_ACTION     = 8'h4C;
   localparam logic [7:0]  CMD_OT_THRESH     = 8'h4F;
   // Reset values of the configuration words.
   localparam logic [15:0] UC_THRESH_RST     = 16'h0000;
   localparam logic [7:0]  UC_ACTION_RST     = 8'h00;
   localparam logic [15:0] OT_THRESH_RST     = 16'h0000;
   // Field positions inside the action byte.
   localparam int          RESP_MSB          = 7;
   localparam int          RESP_LSB          = 6;
   localparam int          RETRY_MSB         = 5;
   localparam int          RETRY_LSB         = 3;
   localparam int          DELAY_MSB         = 2;
   localparam int          DELAY_LSB         = 0;
   // Response field encodings.
   localparam logic [1:0]  RESP_IGNORE       = 2'h0;
   localparam logic [1:0]  RESP_DELAY_RETRY  = 2'h1;
   localparam logic [1:0]  RESP_DISABLE      = 2'h2;
   localparam logic [1:0]  RESP_HOLD_OFF     = 2'h3;
   // Retry field encodings.
   localparam logic [2:0]  RETRY_NONE        = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
   // Timing: unit times in microseconds, clock in MHz.
   localparam int          CLK_MHZ           = 125;
   localparam int          OPER_UNIT_US      = 10000;
   localparam int          RETRY_UNIT_US     = 8200;
   localparam int          OPER_UNIT_CYC     = OPER_UNIT_US * CLK_MHZ;
   localparam int          RETRY_UNIT_CYC    = RETRY_UNIT_US * CLK_MHZ;
   localparam int          UNIT_CNT_W        = 21;
endpackage

// ===== uflt_timer.sv
// Delay timer counting a number of units of a loadable cycle length.
`timescale 1ns/1ps
`default_nettype none
module uflt_timer
(
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_load,
   input  wire logic [2:0]                  i_units,
   input  wire logic [uflt_pkg::UNIT_CNT_W-1:0] i_unit_cycles,
   input  wire logic                        i_abort,
   output logic                             o_done
);
   logic [2:0]                      units_r;
   logic [uflt_pkg::UNIT_CNT_W-1:0] cyc_r;
   logic [uflt_pkg::UNIT_CNT_W-1:0] reload_r;
   logic                            busy_r;
   logic                            last_unit;
   logic                            unit_end;

   assign last_unit = (units_r == 3'h0);
   assign unit_end  = (cyc_r == '0);

   // A count of zero units finishes one cycle after the load.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || i_abort)
      begin
         busy_r   <= 1'b0;
         units_r  <= 3'h0;
         cyc_r    <= '0;
         reload_r <= '0;
         o_done   <= 1'b0;
      end
      else if (i_load)
      begin
         busy_r   <= 1'b1;
         units_r  <= i_units;
         cyc_r    <= i_unit_cycles - 1'b1;
         reload_r <= i_unit_cycles - 1'b1;
         o_done   <= 1'b0;
      end
      else
      begin
         o_done <= busy_r && last_unit;
         if (busy_r && last_unit)
            busy_r <= 1'b0;
         else if (busy_r && unit_end)
         begin
            units_r <= units_r - 3'h1;
            cyc_r   <= reload_r;
         end
         else if (busy_r)
            cyc_r <= cyc_r - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== uflt_host.sv
// Host model that issues configuration writes and reads on the command port.
`timescale 1ns/1ps
`default_nettype none
module uflt_host
(
   input  wire logic        i_clk_sys,
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic [7:0]       o_cmd_code,
   output logic [15:0]      o_wr_data
);
   initial
   begin
      o_wr_en    = 1'b0;
      o_rd_en    = 1'b0;
      o_cmd_code = 8'h00;
      o_wr_data  = 16'h0000;
   end

   // Each request is one strobe cycle, so back-to-back calls leave a gap.
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      @(posedge i_clk_sys);
      o_wr_en    <= 1'b1;
      o_cmd_code <= code;
      o_wr_data  <= data;
      @(posedge i_clk_sys);
      o_wr_en    <= 1'b0;
      o_wr_data  <= ~data;
   endtask

   task automatic rd(input logic [7:0] code);
      @(posedge i_clk_sys);
      o_rd_en    <= 1'b1;
      o_cmd_code <= code;
      @(posedge i_clk_sys);
      o_rd_en    <= 1'b0;
      o_cmd_code <= ~code;
   endtask
endmodule
`default_nettype wire

// ===== uflt_top_tb.sv
// Self-checking testbench of the undercurrent fault response controller.
`timescale 1ns/1ps
`default_nettype none
module uflt_top_tb;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [15:0] i_iout_meas = 16'hffff;
   logic        i_output_on = 1'b1;
   logic        i_other_shutdown = 1'b0;
   logic        i_clear_fault = 1'b0;
   wire         wr_en, rd_en, rd_valid, en, alert_n, st_uc;
   wire  [7:0]  cmd;
   wire  [15:0] wdata, rdata, ot_thr;
   logic [15:0] exp_q[$];
   int          failures = 0;
   int          samples_checked = 0;

   always #4 i_clk_sys = ~i_clk_sys;

   uflt_host host_u (.i_clk_sys(i_clk_sys), .o_wr_en(wr_en), .o_rd_en(rd_en),
      .o_cmd_code(cmd), .o_wr_data(wdata));

   uflt_top #(.P_OPER_UNIT_CYC(20), .P_RETRY_UNIT_CYC(16)) dut_u (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_cmd_code(cmd), .i_wr_data(wdata),
      .i_iout_meas(i_iout_meas), .i_output_on(i_output_on),
      .i_other_shutdown(i_other_shutdown), .i_clear_fault(i_clear_fault),
      .o_rd_data(rdata), .o_rd_valid(rd_valid), .o_output_en(en),
      .o_alert_line_n(alert_n), .o_status_uc(st_uc),
      .o_overtemp_trip_threshold(ot_thr));

   task automatic complete_run();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                      input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic chk_rng(input int t, input int lo, input int hi);
      chk({15'h0000, t >= lo && t <= hi}, 16'h0001, "interval");
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic rdx(input logic [7:0] code, input logic [15:0] exp);
      exp_q.push_back(exp);
      host_u.rd(code);
   endtask

   task automatic drive_meas(input logic [15:0] v);
      @(posedge i_clk_sys);
      i_iout_meas <= v;
   endtask

   task automatic wait_en(input logic v, input int lim, output int t);
      t = 0;
      while (en !== v && t < lim)
      begin
         cyc(1);
         t++;
      end
      if (en !== v)
      begin
         failures++;
         $display("BAD %0t output enable wait ran out", $time);
         complete_run();
      end
   endtask

   // Removes the fault, then clears the latched flags and any latch-off.
   task automatic clean();
      drive_meas(16'h0100);
      @(posedge i_clk_sys);
      i_clear_fault <= 1'b1;
      @(posedge i_clk_sys);
      i_clear_fault <= 1'b0;
      cyc(4);
      chk(st_uc, 1'b0, "status after clear");
      chk(alert_n, 1'b1, "alert after clear");
      chk(en, 1'b1, "output after clear");
   endtask

   always @(posedge i_clk_sys)
   begin
      #1;
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(rdata, 16'hxxxx, "unexpected read");
         else
            chk(rdata, exp_q.pop_front(), "read data");
      end
   end

   initial
   begin
      repeat (60000) @(posedge i_clk_sys);
      failures++;
      $display("BAD %0t run too long", $time);
      complete_run();
   end

   initial
   begin
      int          t;
      logic [15:0] v;
      void'($urandom(32'h3de4bf1b));
      repeat (4) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rdx(uflt_pkg::CMD_UC_THRESH, 16'h0000);
      rdx(uflt_pkg::CMD_UC_ACTION, 16'h0000);
      rdx(uflt_pkg::CMD_OT_THRESH, 16'h0000);
      rdx(8'h4d, 16'h0000);
      v = 16'($urandom);
      host_u.wr(uflt_pkg::CMD_OT_THRESH, v);
      rdx(uflt_pkg::CMD_OT_THRESH, v);
      chk(ot_thr, v, "threshold word");
      v = 16'($urandom);
      host_u.wr(uflt_pkg::CMD_UC_ACTION, {v[15:8], 8'h00});
      rdx(uflt_pkg::CMD_UC_ACTION, 16'h0000);
      host_u.wr(8'h4d, v);
      rdx(8'h4d, 16'h0000);
      host_u.wr(uflt_pkg::CMD_UC_THRESH, 16'h0100);
      rdx(uflt_pkg::CMD_UC_THRESH, 16'h0100);
      $display("test registers done");
      drive_meas(16'h00ff);
      cyc(2);
      chk(st_uc, 1'b1, "status on fault");
      chk(alert_n, 1'b0, "alert on fault");
      cyc(30);
      chk(en, 1'b1, "ignore keeps running");
      clean();
      $display("test ignore done");
      host_u.wr(uflt_pkg::CMD_UC_ACTION, 16'h00c0);
      drive_meas(16'h0010);
      wait_en(1'b0, 3, t);
      cyc(20);
      chk(en, 1'b0, "held off in fault");
      drive_meas(16'h0100);
      wait_en(1'b1, 4, t);
      clean();
      $display("test hold off done");
      host_u.wr(uflt_pkg::CMD_UC_ACTION, 16'h0042);
      drive_meas(16'h0010);
      wait_en(1'b0, 60, t);
      chk_rng(t, 39, 46);
      cyc(40);
      chk(en, 1'b0, "latched after delay");
      clean();
      // One unit of delay, then one restart attempt, then latch-off.
      host_u.wr(uflt_pkg::CMD_UC_ACTION, 16'h0049);
      drive_meas(16'h0010);
      wait_en(1'b0, 40, t);
      chk_rng(t, 19, 26);
      wait_en(1'b1, 30, t);
      chk_rng(t, 15, 20);
      wait_en(1'b0, 30, t);
      chk_rng(t, 15, 20);
      clean();
      // A fault gone before the delay ends leaves the output running.
      host_u.wr(uflt_pkg::CMD_UC_ACTION, 16'h0041);
      drive_meas(16'h0010);
      cyc(5);
      drive_meas(16'h0100);
      cyc(40);
      chk(en, 1'b1, "fault gone before delay end");
      clean();
      $display("test delayed response done");
      for (int n = 0; n < 7; n++)
      begin
         host_u.wr(uflt_pkg::CMD_UC_ACTION, {8'h00, 2'b10, 3'(n), 3'(n)});
         drive_meas(16'h0010);
         wait_en(1'b0, 3, t);
         if (n == 0)
         begin
            cyc(60);
            chk(en, 1'b0, "no retry stays off");
         end
         else
         begin
            wait_en(1'b1, 20 * n + 4, t);
            chk_rng(t, 16 * n - 1, 16 * n + 4);
            wait_en(1'b0, n * (20 * n + 4), t);
            chk_rng(t, n * 16 * n - 1, n * (16 * n + 4));
            cyc(150);
            chk(en, 1'b0, "off after last attempt");
         end
         clean();
      end
      $display("test counted retries done");
      host_u.wr(uflt_pkg::CMD_UC_ACTION, 16'h00bf);
      drive_meas(16'h0010);
      wait_en(1'b0, 3, t);
      wait_en(1'b1, 120, t);
      chk_rng(t, 111, 116);
      // The output stays on across attempts; 900 cycles outlast seven.
      repeat (3)
      begin
         cyc(300);
         chk(en, 1'b1, "restarted");
      end
      @(posedge i_clk_sys);
      i_other_shutdown <= 1'b1;
      cyc(3);
      chk(en, 1'b0, "other fault stops retry");
      @(posedge i_clk_sys);
      i_other_shutdown <= 1'b0;
      clean();
      $display("test endless retry done");
      cyc(4);
      chk(16'(exp_q.size()), 16'h0000, "reads answered");
      complete_run();
   end
endmodule
`default_nettype wire
